// >>> sched_map.svh
`ifndef SCHED_MAP_SVH
`define SCHED_MAP_SVH

// ----------------------------------------------------------------
// session mode codes
// ----------------------------------------------------------------
`define MODE_LOGGING    2'h0
`define MODE_STREAMING  2'h1
`define MODE_DUTY       2'h2
`define MODE_HIGH_SPEED 2'h3

// ----------------------------------------------------------------
// channel layout
// ----------------------------------------------------------------
`define NUM_CHAN 4
`define NUM_AXES 2'h3

// ----------------------------------------------------------------
// logging store geometry
// ----------------------------------------------------------------
`define PAGE_COUNT  21'h001FFF
`define PAGE_POINTS 21'h000084

// ----------------------------------------------------------------
// logging rates: base rate shifted left by the selector
// ----------------------------------------------------------------
`define LOG_RATE_BASE 40'h0000000020
`define LOG_SEL_MAX   5'h06

// ----------------------------------------------------------------
// streaming rates per active channel, one to four channels
// ----------------------------------------------------------------
`define STRM_RATE_1 40'h00000002E0
`define STRM_RATE_2 40'h00000002A7
`define STRM_RATE_3 40'h0000000269
`define STRM_RATE_4 40'h0000000235

// ----------------------------------------------------------------
// high speed streaming rates per active channel
// ----------------------------------------------------------------
`define HSS_RATE_1 40'h0000000FA0
`define HSS_RATE_2 40'h00000007D0
`define HSS_RATE_3 40'h0000000532
`define HSS_RATE_4 40'h00000003E8

// ----------------------------------------------------------------
// low duty cycle rates (per second) and intervals (seconds)
// ----------------------------------------------------------------
`define DUTY_RATE_500 40'h00000001F4
`define DUTY_RATE_250 40'h00000000FA
`define DUTY_RATE_100 40'h0000000064
`define DUTY_RATE_50  40'h0000000032
`define DUTY_RATE_25  40'h0000000019
`define DUTY_RATE_10  40'h000000000A
`define DUTY_RATE_5   40'h0000000005
`define DUTY_RATE_2   40'h0000000002
`define DUTY_RATE_1   40'h0000000001
`define DUTY_SEC_2    40'h0000000002
`define DUTY_SEC_5    40'h0000000005
`define DUTY_SEC_10   40'h000000000A
`define DUTY_SEC_30   40'h000000001E
`define DUTY_SEC_60   40'h000000003C
`define DUTY_SEC_120  40'h0000000078
`define DUTY_SEC_300  40'h000000012C
`define DUTY_SEC_600  40'h0000000258
`define DUTY_SEC_1800 40'h0000000708
`define DUTY_SEC_3600 40'h0000000E10

`endif

// >>> sched_pkg.sv
package sched_pkg;
  `include "sched_map.svh"

  // session modes
  typedef enum logic [1:0]
  {
    mode_logging        = `MODE_LOGGING,
    mode_streaming      = `MODE_STREAMING,
    low_duty_cycle_mode = `MODE_DUTY,
    mode_high_speed     = `MODE_HIGH_SPEED
  } mode_type;

  // sequencer states, one-hot
  typedef enum logic [4:0]
  {
    st_idle    = 5'h01,
    st_wait    = 5'h02,
    st_convert = 5'h04,
    st_scale   = 5'h08,
    st_emit    = 5'h10
  } state_type;
endpackage

// >>> scale_if.sv
`timescale 1ns/100ps
interface scale_if #(
  parameter int RAW_W = 12,
  parameter int CAL_W = 16,
  parameter int FRAC  = 8
);
  localparam int RES_W = CAL_W + FRAC + 2;
  logic                    start;
  logic [RAW_W-1:0]        raw;
  logic [CAL_W-1:0]        gain;
  logic [CAL_W-1:0]        offset;
  logic                    done;
  logic signed [RES_W-1:0] result;

  modport client (output start, output raw, output gain, output offset,
                  input done, input result);
  modport engine (input start, input raw, input gain, input offset,
                  output done, output result);
endinterface

// >>> sample_scaler.sv
`timescale 1ns/100ps
module sample_scaler #(
  parameter int RAW_W = 12,
  parameter int CAL_W = 16,
  parameter int FRAC  = 8
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // scaling request and answer
  scale_if.engine  sc
);
  localparam int N     = CAL_W + 1 + FRAC;
  localparam int CNT_W = $clog2(N + 1);

  logic [CAL_W:0]   diff;
  logic [CAL_W:0]   mag;
  logic [CAL_W:0]   trial;
  logic [N-1:0]     quot;
  logic [CAL_W-1:0] rem;
  logic [CAL_W-1:0] divisor;
  logic             neg;
  logic             busy;
  logic [CNT_W-1:0] count;

  // signed difference of raw reading and offset, and its magnitude
  assign diff  = {{(CAL_W+1-RAW_W){1'b0}}, sc.raw} - {1'b0, sc.offset};
  assign mag   = diff[CAL_W] ? (~diff + 1'b1) : diff;
  assign trial = {rem, quot[N-1]};

  // restoring divider, one quotient bit per cycle
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      quot    <= '0;
      rem     <= '0;
      divisor <= '0;
      neg     <= 1'b0;
      busy    <= 1'b0;
      count   <= '0;
      sc.done <= 1'b0;
    end
    else
    begin
      sc.done <= 1'b0;
      if (!busy && sc.start)
      begin
        quot    <= {mag, {FRAC{1'b0}}};
        rem     <= '0;
        divisor <= sc.gain;
        neg     <= diff[CAL_W];
        busy    <= 1'b1;
        count   <= '0;
      end
      else if (busy)
      begin
        if (trial >= {1'b0, divisor})
        begin
          rem  <= CAL_W'(trial - {1'b0, divisor});
          quot <= {quot[N-2:0], 1'b1};
        end
        else
        begin
          rem  <= trial[CAL_W-1:0];
          quot <= {quot[N-2:0], 1'b0};
        end
        count <= count + 1'b1;
        if (count == CNT_W'(N - 1))
        begin
          busy    <= 1'b0;
          sc.done <= 1'b1;
        end
      end
    end
  end

  // signed quotient in fixed point with FRAC fraction bits
  assign sc.result = neg ? -$signed({1'b0, quot}) : $signed({1'b0, quot});
endmodule

// >>> multi_mode_sample_scheduler.sv
// Overview of operation
// - four modes; logging and low duty rates chosen, streaming rates set by channels
// - logging rates 32 to 2048 per second, doubling steps
// - streaming rates 736, 679, 617, 565 for one to four channels
// - low duty rates 500 down to 1 per second, then slow intervals
// - high speed rates 4000, 2000, 1330, 1000 for one to four channels
// - logging store of 8191 pages of 132 points bounds recording
// - continuous logging ends by itself when the store fills
// - each logging sweep stores one point per enabled channel
// - scaled value is raw minus offset, divided by gain, per axis
// - finite session ends after the programmed count of sweeps
// - low duty and high speed samples carry 16-bit counter stamp
`timescale 1ns/100ps
module multi_mode_sample_scheduler #(
  parameter logic [39:0] CLK_HZ = 40'h0005F5E100,
  parameter int          RAW_W  = 12,
  parameter int          CAL_W  = 16,
  parameter int          FRAC   = 8
)
(
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        resetn,
  // session control
  input  wire logic                        start,
  input  wire logic                        stop,
  input  wire sched_pkg::mode_type         mode_in,
  input  wire logic [3:0]                  chan_mask_in,
  input  wire logic [4:0]                  rate_sel_in,
  input  wire logic [15:0]                 duration_in,
  input  wire logic                        continuous_in,
  input  wire logic                        mem_clear,
  // stored calibration per axis
  input  wire logic [2:0][CAL_W-1:0]       axis_gain,
  input  wire logic [2:0][CAL_W-1:0]       axis_offset,
  // converter side
  output logic                             adc_req,
  output logic [1:0]                       adc_chan,
  input  wire logic                        adc_valid,
  input  wire logic [RAW_W-1:0]            adc_data,
  // sample output
  output logic                             out_valid,
  output logic [1:0]                       out_chan,
  output logic [RAW_W-1:0]                 out_raw,
  output logic signed [CAL_W+FRAC+1:0]     out_scaled,
  output logic [15:0]                      out_stamp,
  output logic                             out_stamp_en,
  output logic                             log_write,
  // session status
  output logic                             session_active,
  output logic                             session_done,
  output logic                             start_reject,
  output logic                             mem_full,
  output logic [20:0]                      mem_used
);
  import sched_pkg::*;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // number of enabled channels
  function automatic logic [2:0] popcount(input logic [3:0] m);
    popcount = 3'(m[0]) + 3'(m[1]) + 3'(m[2]) + 3'(m[3]);
  endfunction

  // lowest enabled channel of a mask
  function automatic logic [1:0] lowest(input logic [3:0] m);
    lowest = m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3;
  endfunction

  // sweep period in clock cycles, zero for an illegal selection
  function automatic logic [39:0] sweep_period(input mode_type m, input logic [4:0] s,
                                               input logic [2:0] n);
    sweep_period = '0;
    unique case (m)
      mode_logging:
        if (s <= `LOG_SEL_MAX)
          sweep_period = CLK_HZ / (`LOG_RATE_BASE << s);
      mode_streaming:
        case (n)
          3'h1: sweep_period = CLK_HZ / `STRM_RATE_1;
          3'h2: sweep_period = CLK_HZ / `STRM_RATE_2;
          3'h3: sweep_period = CLK_HZ / `STRM_RATE_3;
          3'h4: sweep_period = CLK_HZ / `STRM_RATE_4;
          default: sweep_period = '0;
        endcase
      mode_high_speed:
        case (n)
          3'h1: sweep_period = CLK_HZ / `HSS_RATE_1;
          3'h2: sweep_period = CLK_HZ / `HSS_RATE_2;
          3'h3: sweep_period = CLK_HZ / `HSS_RATE_3;
          3'h4: sweep_period = CLK_HZ / `HSS_RATE_4;
          default: sweep_period = '0;
        endcase
      low_duty_cycle_mode:
        case (s)
          5'h00: sweep_period = CLK_HZ / `DUTY_RATE_500;
          5'h01: sweep_period = CLK_HZ / `DUTY_RATE_250;
          5'h02: sweep_period = CLK_HZ / `DUTY_RATE_100;
          5'h03: sweep_period = CLK_HZ / `DUTY_RATE_50;
          5'h04: sweep_period = CLK_HZ / `DUTY_RATE_25;
          5'h05: sweep_period = CLK_HZ / `DUTY_RATE_10;
          5'h06: sweep_period = CLK_HZ / `DUTY_RATE_5;
          5'h07: sweep_period = CLK_HZ / `DUTY_RATE_2;
          5'h08: sweep_period = CLK_HZ / `DUTY_RATE_1;
          5'h09: sweep_period = CLK_HZ * `DUTY_SEC_2;
          5'h0A: sweep_period = CLK_HZ * `DUTY_SEC_5;
          5'h0B: sweep_period = CLK_HZ * `DUTY_SEC_10;
          5'h0C: sweep_period = CLK_HZ * `DUTY_SEC_30;
          5'h0D: sweep_period = CLK_HZ * `DUTY_SEC_60;
          5'h0E: sweep_period = CLK_HZ * `DUTY_SEC_120;
          5'h0F: sweep_period = CLK_HZ * `DUTY_SEC_300;
          5'h10: sweep_period = CLK_HZ * `DUTY_SEC_600;
          5'h11: sweep_period = CLK_HZ * `DUTY_SEC_1800;
          5'h12: sweep_period = CLK_HZ * `DUTY_SEC_3600;
          default: sweep_period = '0;
        endcase
    endcase
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam logic [20:0] CAPACITY = `PAGE_COUNT * `PAGE_POINTS;

  state_type   state;
  state_type   next_state;
  mode_type    sess_mode;
  logic [3:0]  sess_mask;
  logic [2:0]  sess_nchan;
  logic [39:0] sess_period;
  logic [15:0] sess_duration;
  logic        sess_cont;
  logic        stop_req;
  logic [39:0] tick_cnt;
  logic        pending;
  logic [3:0]  pend_mask;
  logic [1:0]  cur_chan;
  logic [15:0] sweeps;
  logic [15:0] stamp;
  logic [2:0]  nchan_in;
  logic [39:0] period_in;
  logic        start_ok;
  logic        mem_short;
  logic        end_now;
  logic        sweep_go;
  logic        emit;
  logic [3:0]  rest_mask;
  logic        last_chan;
  logic        tick;

  scale_if #(.RAW_W(RAW_W), .CAL_W(CAL_W), .FRAC(FRAC)) sc ();

  // ----------------------------------------------------------------
  // sequencing decisions
  // ----------------------------------------------------------------

  // start checks, end conditions and channel walk
  always_comb
  begin
    nchan_in  = popcount(chan_mask_in);
    period_in = sweep_period(mode_in, rate_sel_in, nchan_in);
    start_ok  = (state == st_idle) && start && (nchan_in != 3'h0) && (period_in != '0);
    mem_short = (sess_mode == mode_logging) &&
                ((mem_used + 21'(sess_nchan)) > CAPACITY);
    end_now   = (state == st_wait) &&
                (stop_req || mem_short ||
                 (!sess_cont && (sweeps == sess_duration)));
    sweep_go  = (state == st_wait) && !end_now && pending;
    emit      = (state == st_emit);
    rest_mask = pend_mask & ~(4'h1 << cur_chan);
    last_chan = (rest_mask == 4'h0);
    tick      = (tick_cnt == (sess_period - 40'h1));
  end

  // next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      st_idle:    if (start_ok) next_state = st_wait;
      st_wait:
        if (end_now)
          next_state = st_idle;
        else if (sweep_go)
          next_state = st_convert;
      st_convert:
        if (adc_valid)
          next_state = (cur_chan < `NUM_AXES) ? st_scale : st_emit;
      st_scale:   if (sc.done) next_state = st_emit;
      st_emit:    next_state = last_chan ? st_wait : st_convert;
    endcase
  end

  // ----------------------------------------------------------------
  // state and session registers
  // ----------------------------------------------------------------

  // state register
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      state <= st_idle;
    else
      state <= next_state;
  end

  // session settings captured at start, held until the end
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      sess_mode     <= mode_logging;
      sess_mask     <= 4'h0;
      sess_nchan    <= 3'h0;
      sess_period   <= 40'h0000000001;
      sess_duration <= 16'h0000;
      sess_cont     <= 1'b0;
    end
    else if (start_ok)
    begin
      sess_mode     <= mode_in;
      sess_mask     <= chan_mask_in;
      sess_nchan    <= nchan_in;
      sess_period   <= period_in;
      sess_duration <= duration_in;
      sess_cont     <= continuous_in;
    end
  end

  // stop request held until the session closes
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      stop_req <= 1'b0;
    else if (state == st_idle)
      stop_req <= 1'b0;
    else if (stop)
      stop_req <= 1'b1;
  end

  // sweep timer; a tick in the cycle a sweep starts stays pending
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      tick_cnt <= '0;
      pending  <= 1'b0;
    end
    else if (state == st_idle)
    begin
      tick_cnt <= '0;
      pending  <= 1'b0;
    end
    else
    begin
      tick_cnt <= tick ? '0 : tick_cnt + 40'h1;
      if (tick)
        pending <= 1'b1;
      else if (sweep_go)
        pending <= 1'b0;
    end
  end

  // channel walk inside a sweep
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pend_mask <= 4'h0;
      cur_chan  <= 2'h0;
    end
    else if (sweep_go)
    begin
      pend_mask <= sess_mask;
      cur_chan  <= lowest(sess_mask);
    end
    else if (emit)
    begin
      pend_mask <= rest_mask;
      cur_chan  <= lowest(rest_mask);
    end
  end

  // sweep count and timestamp counter
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      sweeps <= 16'h0000;
      stamp  <= 16'h0000;
    end
    else if (start_ok)
    begin
      sweeps <= 16'h0000;
      stamp  <= 16'h0000;
    end
    else if (emit && last_chan)
    begin
      sweeps <= sweeps + 16'h0001;
      stamp  <= stamp + 16'h0001;
    end
  end

  // logging store usage
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      mem_used <= 21'h000000;
      mem_full <= 1'b0;
    end
    else if ((state == st_idle) && mem_clear)
    begin
      mem_used <= 21'h000000;
      mem_full <= 1'b0;
    end
    else
    begin
      if (emit && (sess_mode == mode_logging))
        mem_used <= mem_used + 21'h000001;
      if (end_now && mem_short)
        mem_full <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // scaling engine
  // ----------------------------------------------------------------
  assign sc.raw    = out_raw;
  assign sc.gain   = axis_gain[cur_chan];
  assign sc.offset = axis_offset[cur_chan];

  // scaling starts one cycle after the reading is captured
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      sc.start <= 1'b0;
    else
      sc.start <= (state == st_convert) && adc_valid && (cur_chan < `NUM_AXES);
  end

  sample_scaler #(.RAW_W(RAW_W), .CAL_W(CAL_W), .FRAC(FRAC)) sample_scaler_i
  (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .sc      (sc)
  );

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------

  // converter requests, sample words and status strobes
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      adc_req        <= 1'b0;
      adc_chan       <= 2'h0;
      out_valid      <= 1'b0;
      out_chan       <= 2'h0;
      out_raw        <= '0;
      out_scaled     <= '0;
      out_stamp      <= 16'h0000;
      out_stamp_en   <= 1'b0;
      log_write      <= 1'b0;
      session_active <= 1'b0;
      session_done   <= 1'b0;
      start_reject   <= 1'b0;
    end
    else
    begin
      adc_req      <= sweep_go || (emit && !last_chan);
      if (sweep_go || (emit && !last_chan))
        adc_chan <= lowest(sweep_go ? sess_mask : rest_mask);
      out_valid    <= emit;
      log_write    <= emit && (sess_mode == mode_logging);
      session_done <= end_now;
      start_reject <= (state == st_idle) && start && !start_ok;
      if (start_ok)
        session_active <= 1'b1;
      else if (end_now)
        session_active <= 1'b0;
      if ((state == st_convert) && adc_valid)
      begin
        out_raw    <= adc_data;
        out_chan   <= cur_chan;
        out_scaled <= $signed({{(CAL_W+FRAC+2-RAW_W){1'b0}}, adc_data});
      end
      else if ((state == st_scale) && sc.done)
        out_scaled <= sc.result;
      if (emit)
      begin
        out_stamp_en <= (sess_mode == low_duty_cycle_mode) ||
                        (sess_mode == mode_high_speed);
        out_stamp    <= ((sess_mode == low_duty_cycle_mode) ||
                         (sess_mode == mode_high_speed)) ? stamp : 16'h0000;
      end
    end
  end
endmodule

// >>> adc_model.sv
`timescale 1ns/100ps
module adc_model
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // conversion request
  input  wire logic       adc_req,
  input  wire logic [1:0] adc_chan,
  input  wire logic       slow,
  // conversion answer
  output logic            adc_valid,
  output logic [11:0]     adc_data
);
  logic       busy;
  logic [3:0] wait_cnt;
  logic [1:0] chan_q;

  // answer each request after one or eight cycles; idle data toggles
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      busy      <= 1'b0;
      wait_cnt  <= 4'h0;
      chan_q    <= 2'h0;
      adc_valid <= 1'b0;
      adc_data  <= 12'h000;
    end
    else
    begin
      adc_valid <= 1'b0;
      adc_data  <= ~adc_data;  // no stale reading between answers
      if (adc_req)
      begin
        busy     <= 1'b1;
        chan_q   <= adc_chan;
        wait_cnt <= slow ? 4'h7 : 4'h0;
      end
      else if (busy && wait_cnt != 4'h0)
        wait_cnt <= wait_cnt - 4'h1;
      else if (busy)
      begin
        busy      <= 1'b0;
        adc_valid <= 1'b1;
        adc_data  <= 12'h900 + {4'h0, chan_q, 6'h00};  // fixed reading per channel
      end
    end
  end
endmodule

// >>> sched_props.sv
`timescale 1ns/100ps
module sched_props
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // session control
  input wire logic        start,
  input wire logic [3:0]  chan_mask_in,
  // converter and samples
  input wire logic        adc_req,
  input wire logic [1:0]  adc_chan,
  input wire logic        out_valid,
  input wire logic [15:0] out_stamp,
  input wire logic        out_stamp_en,
  input wire logic        log_write,
  // session status
  input wire logic        session_active,
  input wire logic        session_done,
  input wire logic        start_reject,
  input wire logic [20:0] mem_used
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // session start and end
  empty_mask_a:
    assert property (start && !session_active && !session_done && chan_mask_in == 4'h0
      |-> ##[1:2] start_reject) else $error("empty mask start not refused");
  start_cause_a:
    assert property ($rose(session_active) |-> $past(start) || $past(start, 2))
      else $error("session began without start");
  reject_idle_a:
    assert property (start_reject |-> !session_active) else $error("refused start ran");
  done_closes_a:
    assert property (session_done |-> !session_active && $past(session_active))
      else $error("done not closing a session");
  done_pulse_a:
    assert property (session_done |=> !session_done) else $error("done longer than a cycle");
  // sweep traffic
  req_pulse_a:
    assert property (adc_req |=> !adc_req) else $error("request longer than a cycle");
  req_active_a:
    assert property (adc_req || out_valid |-> session_active)
      else $error("sample outside a session");
  chan_held_a:
    assert property ($changed(adc_chan) |-> adc_req) else $error("channel moved without request");
  req_answer_a:
    assert property (adc_req |-> ##[2:80] out_valid) else $error("conversion gave no sample");
  write_sample_a:
    assert property (log_write |-> out_valid) else $error("write without sample");
  point_step_a:
    assert property (mem_used > $past(mem_used) |-> mem_used == $past(mem_used) + 21'h1)
      else $error("store count jumped");
  store_bound_a:
    assert property (mem_used <= 21'h107F7C) else $error("store count beyond capacity");
  stamp_absent_a:
    assert property (out_valid && !out_stamp_en |-> out_stamp == 16'h0000)
      else $error("stamp value without stamp");
endmodule

bind multi_mode_sample_scheduler sched_props sched_props_i (.clk_sys(clk_sys), .resetn(resetn),
  .start(start), .chan_mask_in(chan_mask_in), .adc_req(adc_req), .adc_chan(adc_chan),
  .out_valid(out_valid), .out_stamp(out_stamp), .out_stamp_en(out_stamp_en),
  .log_write(log_write), .session_active(session_active), .session_done(session_done),
  .start_reject(start_reject), .mem_used(mem_used));

// >>> multi_mode_sample_scheduler_test.sv
`timescale 1ns/100ps
`define check(name, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("wrong value %s expected %0h seen %0h", name, exp, got); \
    end \
  end
module multi_mode_sample_scheduler_test;
  import sched_pkg::*;
  logic clk_sys, resetn, start, stop, continuous_in, mem_clear, slow, adc_req, adc_valid;
  logic out_valid, out_stamp_en, log_write, session_active, session_done, start_reject, mem_full;
  mode_type           mode_in;
  logic [3:0]         chan_mask_in;
  logic [4:0]         rate_sel_in;
  logic [15:0]        duration_in, out_stamp;
  logic [2:0][15:0]   axis_gain, axis_offset;
  logic [1:0]         adc_chan, out_chan;
  logic [11:0]        adc_data, out_raw;
  logic signed [25:0] out_scaled;
  logic [20:0]        mem_used;
  int                 fails, comparisons, total;

  // design at a 1 MHz rate base and converter model
  multi_mode_sample_scheduler #(.CLK_HZ(40'h00000F4240)) multi_mode_sample_scheduler_i (.*);
  adc_model adc_model_i (.clk_sys(clk_sys), .resetn(resetn), .adc_req(adc_req),
    .adc_chan(adc_chan), .slow(slow), .adc_valid(adc_valid), .adc_data(adc_data));

  // 100 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // verdict
  task automatic results;
    if (fails == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // expected scaled value; temperature passes through
  function automatic logic signed [25:0] scaled(input int c, input logic [11:0] raw);
    longint d;
    longint m;
    if (c == 3)
      return {14'h0, raw};
    d = longint'(raw) - longint'(axis_offset[c]);
    m = (d < 0 ? -d : d) * 256 / longint'(axis_gain[c]);
    return 26'(d < 0 ? -m : m);
  endfunction

  // refused start: no session follows
  task automatic refuse(input mode_type m, input logic [3:0] mask, input logic [4:0] sel);
    logic seen;
    seen = 1'b0;
    {mode_in, chan_mask_in, rate_sel_in, start} = {m, mask, sel, 1'b1};
    @(negedge clk_sys);
    start = 1'b0;
    repeat (3)
    begin
      seen = seen | start_reject;
      `check("idle", 1'b0, session_active)
      @(negedge clk_sys);
    end
    `check("reject", 1'b1, seen)
  endtask

  // two sweep session: order, values, stamp, period, store use
  task automatic run(input mode_type m, input logic [3:0] mask, input logic [4:0] sel,
                     input int per, input logic stamp);
    int n, ec = 0, t, t0 = -1, gap = 0, got = 0, writes = 0;
    logic [11:0] er;
    n = $countones(mask);
    slow = ~slow;
    @(negedge clk_sys);
    {mode_in, chan_mask_in, rate_sel_in, duration_in, start} = {m, mask, sel, 16'h0002, 1'b1};
    @(negedge clk_sys);
    start = 1'b0;
    {mode_in, chan_mask_in, rate_sel_in, duration_in} = {~m, ~mask, ~sel, 16'h0009};
    for (t = 0; t < 3 * per + 400 && session_done !== 1'b1; t++)
    begin
      @(negedge clk_sys);
      if (out_valid)
      begin
        while (!mask[ec])
          ec = (ec + 1) % 4;
        er = 12'h900 + 12'(ec * 64);
        `check("chan", 2'(ec), out_chan)
        `check("raw", er, out_raw)
        `check("scaled", scaled(ec, er), out_scaled)
        `check("stamp", stamp, out_stamp_en)
        `check("stamp value", stamp ? 16'(got / n) : 16'h0000, out_stamp)
        writes += int'(log_write);
        ec = (ec + 1) % 4;
        got++;
      end
      if (adc_req && got % n == 0)
      begin
        gap = t - t0;
        t0 = t;
      end
    end
    if (session_done !== 1'b1)
    begin
      fails++;
      results();
    end
    `check("points", 2 * n, got)
    `check("writes", m == mode_logging ? got : 0, writes)
    `check("rate", 1'b1, gap >= per - 1 && gap <= per + 1)
    total += m == mode_logging ? got : 0;
    `check("used", 21'(total), mem_used)
  endtask

  // stop ends a continuous session
  task automatic halt;
    duration_in = 16'h0002;
    {mode_in, chan_mask_in, continuous_in, start} = {mode_high_speed, 4'h1, 2'h3};
    @(negedge clk_sys);
    start = 1'b0;
    repeat (1200) @(negedge clk_sys);
    `check("running", 1'b1, session_active)
    stop = 1'b1;
    for (int t = 0; t < 300 && session_done !== 1'b1; t++)
      @(negedge clk_sys);
    `check("stopped", 1'b1, session_done)
  endtask

  // main sequence
  initial
  begin
    int strm[4] = '{1358, 1472, 1620, 1769};
    int fast[4] = '{250, 500, 751, 1000};
    int duty[3] = '{2000, 4000, 10000};
    logic [15:0] lo, hi;
    {resetn, start, stop, continuous_in, mem_clear, slow} = 6'h00;
    {mode_in, chan_mask_in, rate_sel_in, duration_in} = {mode_logging, 4'h0, 5'h00, 16'h0000};
    for (int a = 0; a < 3; a++)
    begin
      lo = 16'h0600 + 16'(a) * 16'h0200;
      hi = lo + 16'h0400;
      axis_gain[a] = (hi - lo) / 2;
      axis_offset[a] = (hi + lo) / 2;
    end
    repeat (5) @(negedge clk_sys);
    resetn = 1'b1;
    refuse(mode_logging, 4'h0, 5'h00);
    refuse(mode_logging, 4'h1, 5'h07);
    refuse(low_duty_cycle_mode, 4'h1, 5'h13);
    for (int s = 3; s <= 6; s++)
      run(mode_logging, 4'h7, 5'(s), 1000000 / (32 << s), 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      run(mode_streaming, 4'((2 << k) - 1), 5'h1F, strm[k], 1'b0);
      run(mode_high_speed, 4'((2 << k) - 1), 5'h1F, fast[k], 1'b1);
    end
    for (int s = 0; s < 3; s++)
      run(low_duty_cycle_mode, 4'hF, 5'(s), duty[s], 1'b1);
    halt();
    mem_clear = 1'b1;
    repeat (3) @(negedge clk_sys);
    mem_clear = 1'b0;
    `check("cleared", 21'h000000, mem_used)
    `check("full", 1'b0, mem_full)
    results();
  end
endmodule
